// ### src/sysctl_regs.sv
`timescale 1ns/1ps
`default_nettype none

module sysctl_regs
  import sysctl_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // preemption query
  input  wire logic [7:0]  pend_prio,
  input  wire logic [7:0]  run_prio,
  output logic             preempt,
  // event and low power
  input  wire logic        irq_pending_en,
  input  wire logic        irq_pending_dis,
  input  wire logic        send_event,
  input  wire logic        ext_event,
  input  wire logic        wait_for_event,
  input  wire logic        sleep_req,
  input  wire logic        return_to_thread,
  output logic             wake,
  output logic             sleep_now,
  output logic             deep_now,
  // exception entry and return
  input  wire logic        exc_entry,
  input  wire logic [31:0] sp_in,
  input  wire logic        exception_return_value,
  input  wire logic        saved_pad,
  output logic [31:0]      sp_frame,
  output logic             pad_bit9,
  output logic [31:0]      sp_restore,
  // fault qualification
  input  wire logic        bus_fault,
  input  wire logic        neg_prio,
  input  wire logic        div_zero,
  input  wire logic        access_misaligned,
  input  wire logic        access_multi_or_dbl,
  input  wire logic        trig_write,
  input  wire logic        privileged,
  input  wire logic        others_active,
  output logic             lockup,
  output logic             div_trap,
  output logic             usage_fault,
  output logic             trig_allowed,
  output logic             thread_ok,
  // handler priorities out
  output logic [3:0]       prio_mem,
  output logic [3:0]       prio_bus,
  output logic [3:0]       prio_usage,
  output logic [3:0]       prio_svc,
  output logic [3:0]       prio_pendsv,
  output logic [3:0]       prio_tick
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  group;
    logic [31:0] lp;
    logic [31:0] cc;
    logic [31:0] shp1;
    logic [31:0] shp2;
    logic [31:0] shp3;
    logic        ev_latch;
    logic [7:0]  outs;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  // group priority bits of a value under the current code
  function automatic logic [7:0] group_of(input logic [7:0] p, input logic [2:0] g);
    logic [7:0] m;
    m = 8'hf0;
    if (g > 3'h3)
      m = 8'hf0 << g[2:0] - 3'h3;
    group_of = p & m;
  endfunction : group_of

  // apply byte strobes, keeping only the upper nibble of implemented lanes
  function automatic logic [31:0] prio_write(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] s, input logic [3:0] lanes);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (s[i] && lanes[i])
        r[i*8 +: 8] = {d[i*8+4 +: 4], 4'h0};
    prio_write = r;
  endfunction : prio_write

  wire logic acc = psel && penable;
  wire logic wr  = acc && pwrite;
  wire logic mapped = (paddr <= off_status) && (paddr[1:0] == 2'b00);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    if (wr && mapped)
    begin
      case (paddr)
        off_app_reset_ctrl:
        begin
          if (pwdata[31:16] == write_key && pstrb[1])
            nxt_st.group = pwdata[grp_lsb +: 3];
        end
        off_low_power_ctrl: nxt_st.lp = pwdata & lp_mask;
        off_core_cfg:       nxt_st.cc = pwdata & cc_mask;
        off_shp1:           nxt_st.shp1 = prio_write(st_ff.shp1, pwdata, pstrb, shp1_lanes);
        off_shp2:           nxt_st.shp2 = prio_write(st_ff.shp2, pwdata, pstrb, shp2_lanes);
        off_shp3:           nxt_st.shp3 = prio_write(st_ff.shp3, pwdata, pstrb, shp3_lanes);
        default:            nxt_st.lp = st_ff.lp;
      endcase
    end
    // latch when not waiting, consume on wait
    if (wait_for_event)
      nxt_st.ev_latch = 1'b0;
    else if (irq_pending_en || send_event || ext_event ||
             (st_ff.lp[lp_evpend] && irq_pending_dis))
      nxt_st.ev_latch = 1'b1;
    nxt_st.outs = '0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= '0;
      st_ff.group <= rst_group;
    end
    else
      st_ff <= nxt_st;
  end

  // ----------------------------------------------------------------
  // read path, zero wait states
  // ----------------------------------------------------------------
  always_comb
  begin
    prdata = 32'h0000_0000;
    case (paddr)
      off_app_reset_ctrl: prdata = {read_key, 5'h00, st_ff.group, 8'h00};
      off_low_power_ctrl: prdata = st_ff.lp;
      off_core_cfg:       prdata = st_ff.cc;
      off_shp1:           prdata = st_ff.shp1;
      off_shp2:           prdata = st_ff.shp2;
      off_shp3:           prdata = st_ff.shp3;
      off_status:         prdata = {31'h0, st_ff.ev_latch};
      default:            prdata = 32'h0000_0000;
    endcase
  end
  assign pready  = 1'b1;
  // unmapped addresses answer with an error
  assign pslverr = acc && !mapped;

  // ----------------------------------------------------------------
  // behaviour
  // ----------------------------------------------------------------
  // group portion only
  assign preempt = group_of(pend_prio, st_ff.group) < group_of(run_prio, st_ff.group);
  assign wake = wait_for_event && (st_ff.ev_latch || irq_pending_en || send_event ||
                ext_event || (st_ff.lp[lp_evpend] && irq_pending_dis));
  wire logic go_sleep = sleep_req || (return_to_thread && st_ff.lp[lp_sleep_ret]);
  assign sleep_now = go_sleep && !st_ff.lp[lp_deep];
  assign deep_now  = go_sleep && st_ff.lp[lp_deep];
  // pad recorded in status bit 9
  assign pad_bit9   = exc_entry && st_ff.cc[cc_stack_alignment_select] && sp_in[2];
  assign sp_frame   = st_ff.cc[cc_stack_alignment_select] ? {sp_in[31:3], 3'b000} : {sp_in[31:2], 2'b00};
  assign sp_restore = saved_pad && exception_return_value ? sp_in | 32'h0000_0004 : sp_in;
  // software duty, bit only gates lockup
  assign lockup = bus_fault && neg_prio && !st_ff.cc[cc_busign];
  assign div_trap = div_zero && st_ff.cc[cc_divzero];
  assign usage_fault = access_multi_or_dbl ||
                       (access_misaligned && st_ff.cc[cc_misalign]);
  assign trig_allowed = trig_write && (privileged || st_ff.cc[cc_unpriv]);
  assign thread_ok = !others_active || st_ff.cc[cc_thread_any];
  assign prio_mem    = st_ff.shp1[7:4];
  assign prio_bus    = st_ff.shp1[15:12];
  assign prio_usage  = st_ff.shp1[23:20];
  assign prio_svc    = st_ff.shp2[31:28];
  assign prio_pendsv = st_ff.shp3[23:20];
  assign prio_tick   = st_ff.shp3[31:28];

endmodule : sysctl_regs
`default_nettype wire

// ### src/sysctl_pkg.sv
package sysctl_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, offsets chosen locally)
  // ----------------------------------------------------------------
  localparam logic [7:0] off_app_reset_ctrl = 8'h00;
  localparam logic [7:0] off_low_power_ctrl = 8'h04;
  localparam logic [7:0] off_core_cfg       = 8'h08;
  localparam logic [7:0] off_shp1           = 8'h0c;
  localparam logic [7:0] off_shp2           = 8'h10;
  localparam logic [7:0] off_shp3           = 8'h14;
  localparam logic [7:0] off_status         = 8'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned key_lsb       = 16;
  localparam logic [15:0] write_key     = 16'h05fa;
  localparam logic [15:0] read_key      = 16'hfa05;
  localparam int unsigned grp_lsb       = 8;
  localparam int unsigned lp_sleep_ret  = 1;
  localparam int unsigned lp_deep       = 2;
  localparam int unsigned lp_evpend     = 4;
  localparam int unsigned cc_thread_any = 0;
  localparam int unsigned cc_unpriv     = 1;
  localparam int unsigned cc_misalign   = 3;
  localparam int unsigned cc_divzero    = 4;
  localparam int unsigned cc_busign     = 8;
  localparam int unsigned cc_stack_alignment_select   = 9;
  localparam logic [31:0] lp_mask       = 32'h0000_0016;
  localparam logic [31:0] cc_mask       = 32'h0000_031b;
  // implemented byte lanes of each handler priority register
  localparam logic [3:0]  shp1_lanes    = 4'b0111;
  localparam logic [3:0]  shp2_lanes    = 4'b1000;
  localparam logic [3:0]  shp3_lanes    = 4'b1100;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]  rst_group     = 3'h0;
  localparam logic [31:0] rst_word      = 32'h0000_0000;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } apb_rsp_t;

endpackage : sysctl_pkg

// ### sim/sysctl_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// passive port checks; the ports are grouped to keep the list short
module sysctl_regs_monitor
  import sysctl_pkg::*;
(
  input wire logic        pclk, presetn, psel, penable, pwrite, preempt, wake,
  input wire logic [7:0]  paddr, pend_prio, run_prio,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb, prio_mem, prio_tick,
  input wire logic        send_event, ext_event, wait_for_event, bus_fault, neg_prio,
  input wire logic        lockup, access_multi_or_dbl, usage_fault
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // only the access phase of a write may store
  wire logic wr = psel && penable && pwrite;
  a_mem_prio_store: assert property (wr && paddr == off_shp1 && pstrb[0]
    |=> prio_mem == $past(pwdata[7:4])) else $error("mem priority not stored");
  a_tick_prio_store: assert property (wr && paddr == off_shp3 && pstrb[3]
    |=> prio_tick == $past(pwdata[31:28])) else $error("tick priority not stored");
  a_tick_lane_hold: assert property (wr && paddr == off_shp3 && !pstrb[3]
    |=> $stable(prio_tick)) else $error("tick priority changed by other lane");
  a_preempt_group: assert property (preempt |-> pend_prio[7:4] < run_prio[7:4])
    else $error("preempt with no lower group");
  a_equal_no_preempt: assert property (pend_prio[7:4] == run_prio[7:4] |-> !preempt)
    else $error("preempt on equal priority");
  a_wake_needs_wait: assert property (wake |-> wait_for_event)
    else $error("wake while not waiting");
  a_event_wakes: assert property (wait_for_event && (send_event || ext_event) |-> wake)
    else $error("event did not wake");
  a_lockup_cause: assert property (lockup |-> bus_fault && neg_prio)
    else $error("lockup without fault");
  a_multi_faults: assert property (access_multi_or_dbl |-> usage_fault)
    else $error("multi access did not fault");
  cover property (wr && paddr == off_shp3);
  cover property (preempt);
  cover property (wake);
endmodule : sysctl_regs_monitor
bind sysctl_regs sysctl_regs_monitor sysctl_regs_monitor_i (.*);
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import sysctl_pkg::*;
;
  logic        pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, pready, pslverr;
  logic [7:0]  paddr = '0, pend_prio = '0, run_prio = '0;
  logic [31:0] pwdata = '0, sp_in = '0, prdata, sp_frame, sp_restore, r, cfg;
  logic [3:0]  pstrb = '0, prio_mem, prio_bus, prio_usage, prio_svc, prio_pendsv, prio_tick;
  logic        irq_pending_en = '0, irq_pending_dis = '0, send_event = '0, ext_event = '0;
  logic        wait_for_event = '0, sleep_req = '0, return_to_thread = '0, exc_entry = '0;
  logic        exception_return_value = '0, saved_pad = '0, bus_fault = '0, neg_prio = '0, div_zero = '0;
  logic        access_misaligned = '0, access_multi_or_dbl = '0, trig_write = '0;
  logic        privileged = '0, others_active = '0, preempt, wake, sleep_now, deep_now;
  logic        pad_bit9, lockup, div_trap, usage_fault, trig_allowed, thread_ok;
  logic [63:0] rq [$];  // expected read word and compare mask; empty mask means error
  int          err_count = 0, num_checks = 0, seed = 68;
  always #2 pclk = ~pclk;
  sysctl_regs sysctl_regs_i (.*);
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task c1(input string n, input logic seen, input logic exp);
    chk(n, {31'h0, seen}, {31'h0, exp});
  endtask : c1
  // request held until pready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    // a slave that never answers counts against the run
    if (n >= 50) err_count++;
    {psel, penable} <= 2'b00;
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    rq.push_back({d, m});
    apb(1'b0, a, 32'h0, 4'hf);
  endtask : rd
  // read results compared at the edge that completes the access
  always @(posedge pclk)
    if (psel && penable && !pwrite && pready === 1'b1 && rq.size() > 0)
    begin
      chk("prdata", prdata & rq[0][31:0], rq[0][63:32]);
      c1("pslverr", pslverr, rq[0][31:0] == 32'h0);
      void'(rq.pop_front());
    end
  task final_report;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  initial
  begin
    #40000;
    err_count++;
    final_report;
  end
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(off_app_reset_ctrl, {read_key, 16'h0}, '1);
    for (int i = 1; i < 6; i++) rd(8'(4 * i), 32'h0, '1);
    rd(8'h40, 32'h0, 32'h0);
    apb(1'b1, off_app_reset_ctrl, {16'h1234, 16'h0500}, 4'hf);
    rd(off_app_reset_ctrl, {read_key, 16'h0}, '1);
    // grouping codes 3 to 7 against random priorities, equal ones included
    for (int c = 3; c < 8; c++)
    begin
      apb(1'b1, off_app_reset_ctrl, {write_key, 5'h0, 3'(c), 8'h0}, 4'hf);
      rd(off_app_reset_ctrl, {read_key, 5'h0, 3'(c), 8'h0}, '1);
      repeat (8)
      begin
        @(posedge pclk);
        r = $random(seed);
        pend_prio <= r[7:0];
        run_prio <= r[16] ? r[7:0] : r[15:8];
        #1 c1("preempt", preempt, (pend_prio[7:4] >> (c - 3)) < (run_prio[7:4] >> (c - 3)));
      end
    end
    apb(1'b1, off_low_power_ctrl, '1, 4'hf);
    rd(off_low_power_ctrl, lp_mask, '1);
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, off_low_power_ctrl, {29'h0, k == 0, k == 1, 1'b0}, 4'hf);
      sleep_req <= (k == 0 || k == 3);
      return_to_thread <= (k == 1 || k == 2);
      #1 c1("deep_now", deep_now, k == 0);
      if (k != 0) c1("sleep_now", sleep_now, k != 2);
      @(posedge pclk);
      {sleep_req, return_to_thread} <= 2'b00;
    end
    // a disabled interrupt is latched only with event_on_pending set
    for (int k = 0; k < 2; k++)
    begin
      apb(1'b1, off_low_power_ctrl, {27'h0, k[0], 4'h0}, 4'hf);
      irq_pending_dis <= 1'b1;
      @(posedge pclk);
      irq_pending_dis <= 1'b0;
      rd(off_status, {31'h0, k[0]}, 32'h1);
      wait_for_event <= 1'b1;
      #1 c1("wake", wake, k[0]);
      @(posedge pclk);
      #1 c1("wake", wake, 1'b0);
      {irq_pending_en, ext_event} <= {~k[0], k[0]};
      #4 c1("wake", wake, 1'b1);
      {irq_pending_en, ext_event, wait_for_event} <= 3'b000;
    end
    // ignore bit set for the first 12 cycles, then cleared so bus_fault with neg_prio gives lockup
    apb(1'b1, off_core_cfg, '1, 4'hf);
    rd(off_core_cfg, cc_mask, '1);
    for (int k = 0; k < 24; k++)
    begin
      if (k == 12) apb(1'b1, off_core_cfg, 32'h0, 4'hf);
      cfg = (k < 12) ? cc_mask : 32'h0;
      @(posedge pclk);
      r = $random(seed);
      {bus_fault, neg_prio, div_zero, access_misaligned, access_multi_or_dbl} <= r[4:0];
      {trig_write, privileged, others_active, exc_entry, exception_return_value, saved_pad} <= r[10:5];
      sp_in <= {r[31:11], 11'h0} | {21'h0, r[11:10], 9'h0} | 32'h4 & {29'h0, r[12], 2'b0};
      #1 c1("lockup", lockup, bus_fault & neg_prio & ~cfg[cc_busign]);
      c1("div_trap", div_trap, div_zero & cfg[cc_divzero]);
      c1("usage", usage_fault, access_misaligned & cfg[cc_misalign] | access_multi_or_dbl);
      c1("trig", trig_allowed, trig_write & (privileged | cfg[cc_unpriv]));
      c1("thread_ok", thread_ok, ~others_active | cfg[cc_thread_any]);
      chk("sp_frame", sp_frame, sp_in & (cfg[cc_stack_alignment_select] ? ~32'h7 : ~32'h3));
      c1("pad_bit9", pad_bit9, exc_entry & cfg[cc_stack_alignment_select] & sp_in[2]);
      if (exception_return_value && saved_pad) chk("sp_restore", sp_restore, sp_in | 32'h4);
    end
    for (int k = 0; k < 3; k++) apb(1'b1, off_shp1 + 8'(4 * k), '1, 4'hf);
    rd(off_shp1, 32'h00f0f0f0, '1);
    rd(off_shp2, 32'hf0000000, '1);
    apb(1'b1, off_shp3, 32'h12a5_3c4d, 4'b0100);
    apb(1'b1, off_shp1, 32'h0000_003c, 4'b0001);
    rd(off_shp3, 32'hf0a00000, '1);
    rd(off_shp1, 32'h00f0f030, '1);
    chk("prio", {8'h0, prio_mem, prio_bus, prio_usage, prio_svc, prio_pendsv, prio_tick},
        32'h003fffaf);
    final_report;
  end
endmodule : tb_top
`default_nettype wire
